//--- hdl/isfl_pkg.sv
// Contract
// R01: After each slave acknowledge slot in master transmit, ack flag shows NACK; the code loads ack_nack instead, so an ACK reads zero.
// R02: Transmit-in-progress sets at master transmit start, clears after slave acknowledge.
// R03: Bus collision flag sets on any master collision; only software clears it.
// R04: General call flag sets on general call address, clears on Stop.
// R05: Ten-bit flag sets on matching second address byte, clears on Stop.
// R06: Transmit buffer write while busy is discarded and sets write collision flag.
// R07: Receive transfer into a still full buffer sets overflow; only software clears.
// R08: Slave data/address flag clears on address match, sets on data byte.
// R09: Stop flag is one only when the last bus condition was a Stop.
// R10: Status bits 13 to 11 read zero and ignore writes.
// R11: Flags reset to zero; software writes only clear clearable flags.
// R12: Status flag positions follow the fixed bit layout from 15 down to 0.
package isfl_pkg;
  localparam logic [7:0] ISFL_OFF_STATUS = 8'h00;
  localparam logic [7:0] ISFL_OFF_EVENT = 8'h04;
  localparam logic [7:0] ISFL_OFF_MASK = 8'h08;
  localparam logic [7:0] ISFL_OFF_TXBUF = 8'h0c;
  localparam int ISFL_ACK_BIT = 15;
  localparam int ISFL_TRS_BIT = 14;
  localparam int ISFL_BCL_BIT = 10;
  localparam int ISFL_GC_BIT = 9;
  localparam int ISFL_TEN_BIT = 8;
  localparam int ISFL_WCOL_BIT = 7;
  localparam int ISFL_OV_BIT = 6;
  localparam int ISFL_DA_BIT = 5;
  localparam int ISFL_STOP_BIT = 4;
  localparam logic [15:0] ISFL_STATUS_RST = 16'h0000;
  localparam logic [5:0] ISFL_EVENT_RST = 6'h00;
  localparam logic [5:0] ISFL_MASK_RST = 6'h00;
  localparam int ISFL_EV_STOP = 0;
  localparam int ISFL_EV_START = 1;
  localparam int ISFL_EV_BCL = 2;
  localparam int ISFL_EV_WCOL = 3;
  localparam int ISFL_EV_OV = 4;
  localparam int ISFL_EV_GC = 5;
  localparam logic [1:0] ISFL_RESP_OKAY = 2'b00;
  localparam logic [1:0] ISFL_RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic ack_slot_done;
    logic ack_nack;
    logic master_tx_start;
    logic collision;
    logic gc_match;
    logic ten_bit_match;
    logic addr_match;
    logic data_byte_rx;
    logic rsr_transfer;
    logic rcv_full;
    logic busy;
  } isfl_evt_s;
endpackage

//--- hdl/isfl_status.sv
// The register offsets and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
module isfl_status
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire isfl_pkg::isfl_evt_s evt,
  input wire logic [3:0] low_flags,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic [15:0] bus_status_register,
  output logic tx_load,
  output logic [7:0] tx_data,
  output logic irq
);
  import isfl_pkg::*;

  logic scl_s1, scl_s2, sda_s1, sda_s2, sda_d;
  logic start_det, stop_det;
  logic ack_reg, trs_reg, bcl_reg, gc_reg, ten_reg, wcol_reg, ov_reg, da_reg, stop_reg;
  logic [5:0] event_reg, mask_reg, event_set;
  logic aw_hold, w_hold, bvalid_reg, rvalid_reg, tx_load_reg;
  logic [7:0] awaddr_reg, tx_data_reg;
  logic [31:0] wdata_reg, rdata_reg;
  logic [3:0] wstrb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  wire wr_fire = aw_hold & w_hold & ~bvalid_reg;
  wire [31:0] strb_mask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}},
                           {8{wstrb_reg[0]}}};
  wire [31:0] wbits = wdata_reg & strb_mask;
  wire wr_status = wr_fire & (awaddr_reg == ISFL_OFF_STATUS);
  wire wr_event = wr_fire & (awaddr_reg == ISFL_OFF_EVENT);
  wire wr_mask = wr_fire & (awaddr_reg == ISFL_OFF_MASK);
  wire wr_txbuf = wr_fire & (awaddr_reg == ISFL_OFF_TXBUF) & wstrb_reg[0];
  wire wr_mapped = (awaddr_reg == ISFL_OFF_STATUS) | (awaddr_reg == ISFL_OFF_EVENT) |
                   (awaddr_reg == ISFL_OFF_MASK) | (awaddr_reg == ISFL_OFF_TXBUF);
  wire bcl_clr = wr_status & wbits[ISFL_BCL_BIT];
  wire wcol_clr = wr_status & wbits[ISFL_WCOL_BIT];
  wire ov_clr = wr_status & wbits[ISFL_OV_BIT];
  wire wcol_set = wr_txbuf & evt.busy;
  wire ov_set = evt.rsr_transfer & evt.rcv_full;
  wire rd_fire = s_axi_arvalid & ~rvalid_reg;
  wire [7:0] rd_addr = {s_axi_araddr[7:2], 2'b00};
  wire rd_mapped = (rd_addr == ISFL_OFF_STATUS) | (rd_addr == ISFL_OFF_EVENT) |
                   (rd_addr == ISFL_OFF_MASK) | (rd_addr == ISFL_OFF_TXBUF);
  wire [15:0] status_word = {ack_reg, trs_reg, 3'b000, bcl_reg, gc_reg, ten_reg,
                             wcol_reg, ov_reg, da_reg, stop_reg, low_flags}; // R12 R10
  wire [31:0] rd_mux = (rd_addr == ISFL_OFF_STATUS) ? {16'h0000, status_word} :
                       (rd_addr == ISFL_OFF_EVENT) ? {26'h0, event_reg} :
                       (rd_addr == ISFL_OFF_MASK) ? {26'h0, mask_reg} :
                       (rd_addr == ISFL_OFF_TXBUF) ? {24'h000000, tx_data_reg} :
                       32'h00000000;

  assign start_det = scl_s2 & sda_d & ~sda_s2;
  assign stop_det = scl_s2 & ~sda_d & sda_s2;
  assign event_set = {evt.gc_match, ov_set, wcol_set, evt.collision, start_det, stop_det};
  assign s_axi_awready = ~aw_hold & ~bvalid_reg;
  assign s_axi_wready = ~w_hold & ~bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign bus_status_register = status_word;
  assign tx_load = tx_load_reg;
  assign tx_data = tx_data_reg;
  assign irq = |(event_reg & mask_reg);

  // Bus pins are sampled twice before the condition detectors look at them.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {ack_reg, trs_reg, bcl_reg, gc_reg, ten_reg} <= ISFL_STATUS_RST[4:0]; // R11
      {wcol_reg, ov_reg, da_reg, stop_reg} <= ISFL_STATUS_RST[3:0]; // R11
    end
    else
    begin
      if (evt.ack_slot_done)
        ack_reg <= evt.ack_nack; // R01
      if (evt.master_tx_start)
        trs_reg <= 1'b1; // R02
      else if (evt.ack_slot_done)
        trs_reg <= 1'b0; // R02
      if (evt.collision)
        bcl_reg <= 1'b1; // R03
      else if (bcl_clr)
        bcl_reg <= 1'b0; // R11
      if (evt.gc_match)
        gc_reg <= 1'b1; // R04
      else if (stop_det)
        gc_reg <= 1'b0; // R04
      if (evt.ten_bit_match)
        ten_reg <= 1'b1; // R05
      else if (stop_det)
        ten_reg <= 1'b0; // R05
      if (wcol_set)
        wcol_reg <= 1'b1; // R06
      else if (wcol_clr)
        wcol_reg <= 1'b0; // R11
      if (ov_set)
        ov_reg <= 1'b1; // R07
      else if (ov_clr)
        ov_reg <= 1'b0; // R11
      if (evt.data_byte_rx)
        da_reg <= 1'b1; // R08
      else if (evt.addr_match)
        da_reg <= 1'b0; // R08
      if (stop_det)
        stop_reg <= 1'b1; // R09
      else if (start_det)
        stop_reg <= 1'b0; // R09
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      event_reg <= ISFL_EVENT_RST;
      mask_reg <= ISFL_MASK_RST;
    end
    else
    begin
      event_reg <= event_set | (event_reg & ~(wr_event ? wbits[5:0] : 6'h00));
      if (wr_mask)
        mask_reg <= wbits[5:0];
    end
  end

  // A busy module keeps its old transmit byte; the write is dropped.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_data_reg <= 8'h00;
      tx_load_reg <= 1'b0;
    end
    else
    begin
      tx_load_reg <= wr_txbuf & ~evt.busy; // R06
      if (wr_txbuf & ~evt.busy)
        tx_data_reg <= wdata_reg[7:0]; // R06
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= ISFL_RESP_OKAY;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_hold <= 1'b1;
        awaddr_reg <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_hold <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_mapped ? ISFL_RESP_OKAY : ISFL_RESP_SLVERR;
      end
      else if (bvalid_reg & s_axi_bready)
      begin
        bvalid_reg <= 1'b0;
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= ISFL_RESP_OKAY;
    end
    else if (rd_fire)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_mux;
      rresp_reg <= rd_mapped ? ISFL_RESP_OKAY : ISFL_RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_reg <= 1'b0;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_txbuf_busy;
    wr_txbuf && evt.busy;
  endsequence

  sequence s_discard;
    wcol_reg && !tx_load_reg;
  endsequence

  a_ack_result: assert property (evt.ack_slot_done |=> ack_reg == $past(evt.ack_nack)) // R01
    else $error("ack flag not updated after ack slot");
  a_trs_span: assert property (evt.master_tx_start |=> trs_reg throughout
    (!evt.ack_slot_done [*1] ##0 1'b1)) // R02
    else $error("transmit flag not set at start");
  a_trs_clear: assert property ((evt.ack_slot_done && !evt.master_tx_start) |=> !trs_reg) // R02
    else $error("transmit flag not cleared after ack");
  a_bcl_sticky: assert property ((bcl_reg && !bcl_clr) |=> bcl_reg) // R03
    else $error("collision flag cleared by hardware");
  a_gc_stop: assert property ((stop_det && !evt.gc_match) |=> !gc_reg) // R04
    else $error("general call flag kept over stop");
  a_ten_set: assert property (evt.ten_bit_match |=> ten_reg) // R05
    else $error("ten bit flag not set");
  a_wcol_drop: assert property (s_txbuf_busy |=> s_discard) // R06
    else $error("busy write not discarded");
  a_ov_set: assert property (ov_set |=> ov_reg && event_reg[ISFL_EV_OV]) // R07
    else $error("overflow flag not set");
  a_da_order: assert property ((evt.addr_match && !evt.data_byte_rx) |=> !da_reg) // R08
    else $error("data address flag not cleared on match");
  a_stop_last: assert property ($rose(stop_reg) |-> $past(stop_det) && !$past(start_det)) // R09
    else $error("stop flag rose without stop");
  a_unimpl_zero: assert property ((rd_fire && s_axi_araddr == ISFL_OFF_STATUS)
    |=> rdata_reg[13:11] == 3'b000) // R10
    else $error("unimplemented bits read nonzero");
  a_set_only_hw: assert property ($rose(wcol_reg) |-> $past(wcol_set)) // R11
    else $error("write collision flag set without cause");
  a_status_map: assert property ((rd_fire && s_axi_araddr == ISFL_OFF_STATUS)
    |=> rdata_reg[15:14] == {$past(ack_reg), $past(trs_reg)}) // R12
    else $error("status layout mismatch");
  // Hardware only sets the sticky flags; they stay up until software clears them.
  a_bcl_set: assert property (evt.collision |=> bcl_reg) // R03
    else $error("collision flag not set");
  a_gc_set: assert property (evt.gc_match |=> gc_reg) // R04
    else $error("general call flag not set");
  a_ten_stop: assert property ((stop_det && !evt.ten_bit_match) |=> !ten_reg) // R05
    else $error("ten bit flag kept over stop");
  a_wcol_sticky: assert property ((wcol_reg && !wcol_clr) |=> wcol_reg) // R06
    else $error("write collision flag cleared by hardware");
  a_load_free: assert property ((wr_txbuf && !evt.busy) |=> tx_load_reg) // R06
    else $error("idle transmit write not loaded");
  a_ov_sticky: assert property ((ov_reg && !ov_clr) |=> ov_reg) // R07
    else $error("overflow flag cleared by hardware");
  a_da_set: assert property (evt.data_byte_rx |=> da_reg) // R08
    else $error("data address flag not set on data");
  a_stop_set: assert property (stop_det |=> stop_reg) // R09
    else $error("stop flag not set on stop");
  a_stop_clear: assert property ((start_det && !stop_det) |=> !stop_reg) // R09
    else $error("stop flag kept over start");
  a_ack_hold: assert property (!evt.ack_slot_done |=> $stable(ack_reg)) // R01
    else $error("ack flag changed outside ack slot");
  a_clr_only: assert property ((wr_status && !evt.collision && !bcl_reg) |=> !bcl_reg) // R11
    else $error("software write set the collision flag");
endmodule // isfl_status

//--- verification/isfl_bus_model.sv
`timescale 1ns/1ps
module isfl_bus_model
(
  input wire logic start_req,
  input wire logic stop_req,
  output logic scl,
  output logic sda
);
  // Both lines rest at the pull-up level, and the clock stands still outside frames.
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // A start, or a repeated start from a low clock, drops data while the clock is high.
  always @(posedge start_req)
  begin
    sda = 1'b1;
    #80;
    scl = 1'b1;
    #80;
    sda = 1'b0;
    #160;
    scl = 1'b0;
  end
  // A stop raises data while the clock is high, then leaves the bus released.
  always @(posedge stop_req)
  begin
    sda = 1'b0;
    #160;
    scl = 1'b1;
    #160;
    sda = 1'b1;
  end
endmodule // isfl_bus_model

//--- verification/isfl_status_tb_top.sv
`timescale 1ns/1ps
module isfl_status_tb_top;
  import isfl_pkg::*;
  localparam logic [1:0] ok = ISFL_RESP_OKAY;
  localparam logic [1:0] err = ISFL_RESP_SLVERR;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, tx_load, irq, scl, sda;
  logic [1:0] bresp, rresp;
  logic start_req = 1'b0, stop_req = 1'b0;
  logic [3:0] low_flags = 4'ha;
  logic [15:0] status;
  logic [7:0] tx_data;
  isfl_evt_s evt = '0;
  int n_fail = 0, samples_checked = 0, n_load = 0;

  always #20 aclk = ~aclk;
  always @(posedge aclk) if (tx_load === 1'b1) n_load <= n_load + 1;

  isfl_bus_model bus (.start_req(start_req), .stop_req(stop_req), .scl(scl), .sda(sda));
  isfl_status uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .evt(evt),
    .low_flags(low_flags), .scl_in(scl), .sda_in(sda), .bus_status_register(status),
    .tx_load(tx_load), .tx_data(tx_data), .irq(irq));

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Ready levels are looked at mid-cycle; they hold until the edge that samples them.
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ta, tw, tb;
    logic [1:0] br;
    tb = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!tb)
    begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      br = bresp;
      @(posedge aclk);
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
    end
    bready <= 1'b0;
    @(posedge aclk);
    chk({30'h0, br}, {30'h0, r});
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] rs;
    tr = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!tr)
    begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      d = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ta)
        arvalid <= 1'b0;
    end
    rready <= 1'b0;
    @(posedge aclk);
    chk(d, e);
    chk({30'h0, rs}, {30'h0, r});
  endtask

  // Pulses the given event inputs for one cycle; busy and receive-full levels persist.
  task ev(input logic [10:0] p);
    evt <= evt | p;
    @(posedge aclk);
    evt <= evt & 11'h003;
    @(posedge aclk);
  endtask

  task cond(input logic stop);
    if (stop) stop_req <= 1'b1;
    else start_req <= 1'b1;
    repeat (30) @(posedge aclk);
    stop_req <= 1'b0;
    start_req <= 1'b0;
    @(posedge aclk);
  endtask

  task test_done;
    $display("checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    #200000;
    n_fail++;
    test_done;
  end

  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(ISFL_OFF_STATUS, 32'h0000000a, ok);
    rd(ISFL_OFF_MASK, 32'h0, ok);
    wr(ISFL_OFF_STATUS, 32'hffffffff, ok);
    rd(ISFL_OFF_STATUS, 32'h0000000a, ok);
    $display("test reset done");
    ev(11'h100);
    rd(ISFL_OFF_STATUS, 32'h0000400a, ok);
    ev(11'h600);
    rd(ISFL_OFF_STATUS, 32'h0000800a, ok);
    ev(11'h500);
    rd(ISFL_OFF_STATUS, 32'h0000400a, ok);
    $display("test acknowledge done");
    wr(ISFL_OFF_MASK, 32'h4, ok);
    chk({31'h0, irq}, 32'h0);
    ev(11'h080);
    chk({31'h0, irq}, 32'h1);
    wr(ISFL_OFF_STATUS, 32'h0000fbff, ok);
    rd(ISFL_OFF_STATUS, 32'h0000440a, ok);
    wr(ISFL_OFF_STATUS, 32'h00000400, ok);
    rd(ISFL_OFF_STATUS, 32'h0000400a, ok);
    wr(ISFL_OFF_MASK, 32'h0, ok);
    chk({31'h0, irq}, 32'h0);
    rd(ISFL_OFF_EVENT, 32'h4, ok);
    wr(ISFL_OFF_EVENT, 32'h4, ok);
    rd(ISFL_OFF_EVENT, 32'h0, ok);
    $display("test collision done");
    cond(1'b0);
    ev(11'h460);
    rd(ISFL_OFF_STATUS, 32'h0000030a, ok);
    cond(1'b1);
    rd(ISFL_OFF_STATUS, 32'h0000001a, ok);
    cond(1'b0);
    rd(ISFL_OFF_STATUS, 32'h0000000a, ok);
    cond(1'b1);
    $display("test bus conditions done");
    evt.busy <= 1'b1;
    wr(ISFL_OFF_TXBUF, 32'h5a, ok);
    chk(32'(n_load), 32'h0);
    evt.busy <= 1'b0;
    wr(ISFL_OFF_TXBUF, 32'h3c, ok);
    rd(ISFL_OFF_TXBUF, 32'h3c, ok);
    chk({24'h000000, tx_data}, 32'h0000003c);
    chk(32'(n_load), 32'h1);
    rd(ISFL_OFF_STATUS, 32'h0000009a, ok);
    wr(ISFL_OFF_STATUS, 32'h80, ok);
    $display("test write collision done");
    ev(11'h006);
    ev(11'h008);
    rd(ISFL_OFF_STATUS, 32'h0000007a, ok);
    evt.rcv_full <= 1'b0;
    wr(ISFL_OFF_STATUS, 32'h40, ok);
    ev(11'h014);
    rd(ISFL_OFF_STATUS, 32'h0000001a, ok);
    chk({16'h0000, status}, 32'h0000001a);
    wr(8'h20, 32'hff, err);
    rd(8'h20, 32'h0, err);
    $display("test receive and unmapped done");
    test_done;
  end
endmodule // isfl_status_tb_top
